// >>> src/macreg_params.svh
`ifndef MACREG_PARAMS_SVH
`define MACREG_PARAMS_SVH
`define MACREG_ADDR_W 8
`define MACREG_OFF_EXT5 8'h0a
`define MACREG_OFF_EXT6 8'h0b
`define MACREG_OFF_EXT7 8'h0c
`define MACREG_OFF_RXCTL 8'h0d
`define MACREG_OFF_ORDER 8'h10
`define MACREG_OFF_CSMA 8'h11
`define MACREG_OFF_ACK 8'h12
`define MACREG_OFF_SLOT 8'h13
`define MACREG_OFF_SWITCH 8'h21
`define MACREG_RST_EXT 8'h00
`define MACREG_RST_RXCTL 8'h00
`define MACREG_RST_ORDER 8'hff
`define MACREG_RST_CSMA 8'h1c
`define MACREG_RST_ACK 8'h39
`define MACREG_RST_SLOT 8'h00
`define MACREG_RST_SWITCH 8'h00
`define MACREG_RXCTL_WMASK 8'h6e
`define MACREG_BIT_WAKE_POL 6
`define MACREG_BIT_WAKE_EN 5
`define MACREG_BIT_CMD_ONLY 3
`define MACREG_BIT_DATA_ONLY 2
`define MACREG_BIT_BCN_ONLY 1
`define MACREG_BIT_PTR_RST 0
`define MACREG_BIT_NO_CS 7
`define MACREG_BIT_BLE 6
`define MACREG_BIT_SLOTTED 5
`define MACREG_BIT_PEND_ACK 7
`define MACREG_BIT_SLOT_SWITCH 1
`define MACREG_ORDER_NONE 4'hf
`define MACREG_BF_MAX 3'h5
`endif

// >>> src/macreg_pkg.sv
package macreg_pkg;
    typedef logic [7:0] macreg_byte_t;
    typedef enum logic [2:0] {
        MACREG_FT_BEACON,
        MACREG_FT_DATA,
        MACREG_FT_ACK,
        MACREG_FT_CMD,
        MACREG_FT_OTHER
    } macreg_ftype_e;
    typedef struct packed {
        macreg_byte_t ext5;
        macreg_byte_t ext6;
        macreg_byte_t ext7;
        macreg_byte_t rxctl;
        macreg_byte_t order;
        macreg_byte_t csma;
        macreg_byte_t ack;
        macreg_byte_t slot;
        macreg_byte_t sw;
        macreg_byte_t rdata;
        logic ptr_rst;
        logic frame_accept;
        logic wake_out;
        logic wake_oe_b;
        logic wake_in_s1;
        logic wake_in_s2;
        logic wake_evt;
        logic beacon_en;
        logic active_en;
        logic csma_bypass;
        logic ca_en;
        logic [2:0] max_backoff;
        logic bf_valid;
        logic pend_bit;
    } macreg_state_s;
endpackage

// >>> src/macreg_top.sv
// Operation
// RL1: extended address high bytes, writable, reset zero
// RL2: wake polarity bit six, default active low
// RL3: wake pin enable bit five, default off
// RL4: command-only filter accepts only command frames
// RL5: data-only filter accepts only data frames
// RL6: beacon-only filter accepts only beacon frames
// RL7: flush bit resets rx pointer, self-clears
// RL8: beacon order, fifteen means no beacon
// RL9: superframe order, fifteen means no active portion
// RL10: software keeps superframe order within beacon order
// RL11: no-carrier-sense skips CSMA when slot switch set and slotted bit five clear
// RL12: battery life extension enable bit six
// RL13: slotted CSMA enable bit five
// RL14: min backoff exponent reset three, zero disables
// RL15: max backoff count, reset four, five max
// RL16: pending-data ack sets frame pending bit
// RL17: ack wait symbols, reset 0x39
// RL18: first guaranteed slot end, upper nibble
// RL19: contention period end, lower nibble
// RL20: software writes reserved bits as zero
// RL21: flush bit always reads back zero
`timescale 1ns/1ps
`include "macreg_params.svh"
module macreg_top
    import macreg_pkg::*;
(
    input wire logic sys_clk_i, // 10 MHz
    input wire logic rst_b_i, // sync reset, active low
    input wire logic [7:0] addr_i, // register address
    input wire logic [7:0] wdata_i, // write data
    input wire logic wr_i, // write strobe
    input wire logic rd_i, // read strobe
    output logic [7:0] rdata_o, // read data, cycle after rd_i
    input wire logic [2:0] rx_ftype_i, // received frame type
    input wire logic wake_pin_i, // wake pin level in
    input wire logic wake_req_i, // internal wake request
    output logic wake_pin_o, // wake pin level out
    output logic wake_pin_oe_b_o, // low while driving
    output logic wake_evt_o, // wake seen on pin, polarity applied
    output logic frame_accept_o, // current frame passes filter
    output logic rx_ptr_rst_o, // one-cycle receive pointer reset
    output logic [63:40] ext_addr_hi_o, // extended address top bytes
    output logic beacon_en_o, // beacons transmitted
    output logic active_en_o, // active portion follows beacon
    output logic [3:0] beacon_order_o, // beacon order
    output logic [3:0] superframe_order_o, // superframe order
    output logic csma_bypass_o, // skip CSMA-CA this transmit
    output logic ble_en_o, // battery life extension
    output logic slotted_o, // slotted CSMA-CA
    output logic ca_en_o, // collision avoidance active
    output logic [1:0] min_be_o, // min backoff exponent
    output logic [2:0] max_backoff_o, // max backoffs, clamped
    output logic backoff_valid_o, // programmed count is defined
    output logic pend_bit_o, // frame pending bit for data request ack
    output logic [6:0] ack_wait_o, // ack wait symbols
    output logic [3:0] first_slot_end_o, // first guaranteed slot end
    output logic [3:0] contention_period_end_o // contention period end
);
    macreg_state_s q;
    macreg_state_s next_q;
    logic [2:0] bf;
    logic wake_lvl;

    always_comb begin
        next_q = q;
        bf = 3'h0;
        wake_lvl = 1'b0;
        next_q.ptr_rst = 1'b0;
        next_q.rdata = 8'h00;
        if (wr_i) begin
            case (addr_i)
                `MACREG_OFF_EXT5: next_q.ext5 = wdata_i; // [RL1]
                `MACREG_OFF_EXT6: next_q.ext6 = wdata_i; // [RL1]
                `MACREG_OFF_EXT7: next_q.ext7 = wdata_i; // [RL1]
                `MACREG_OFF_RXCTL: begin
                    // reserved bits dropped so they read zero
                    next_q.rxctl = wdata_i & `MACREG_RXCTL_WMASK; // [RL2] [RL3] [RL20]
                    next_q.ptr_rst = wdata_i[`MACREG_BIT_PTR_RST]; // [RL7]
                end
                `MACREG_OFF_ORDER: next_q.order = wdata_i; // [RL8] [RL9]
                `MACREG_OFF_CSMA: next_q.csma = wdata_i; // [RL12] [RL13]
                `MACREG_OFF_ACK: next_q.ack = wdata_i; // [RL16] [RL17]
                `MACREG_OFF_SLOT: next_q.slot = wdata_i; // [RL18] [RL19]
                `MACREG_OFF_SWITCH: begin
                    next_q.sw = wdata_i & (8'h01 << `MACREG_BIT_SLOT_SWITCH);
                end
                default: begin
                end
            endcase
        end
        if (rd_i) begin
            case (addr_i)
                `MACREG_OFF_EXT5: next_q.rdata = q.ext5;
                `MACREG_OFF_EXT6: next_q.rdata = q.ext6;
                `MACREG_OFF_EXT7: next_q.rdata = q.ext7;
                `MACREG_OFF_RXCTL: next_q.rdata = q.rxctl; // [RL21]
                `MACREG_OFF_ORDER: next_q.rdata = q.order;
                `MACREG_OFF_CSMA: next_q.rdata = q.csma;
                `MACREG_OFF_ACK: next_q.rdata = q.ack;
                `MACREG_OFF_SLOT: next_q.rdata = q.slot;
                `MACREG_OFF_SWITCH: next_q.rdata = q.sw;
                default: next_q.rdata = 8'h00;
            endcase
        end
        // filters combine: any set filter must match
        next_q.frame_accept = 1'b1;
        if (q.rxctl[`MACREG_BIT_CMD_ONLY] && rx_ftype_i != MACREG_FT_CMD) begin
            next_q.frame_accept = 1'b0; // [RL4]
        end
        if (q.rxctl[`MACREG_BIT_DATA_ONLY] && rx_ftype_i != MACREG_FT_DATA) begin
            next_q.frame_accept = 1'b0; // [RL5]
        end
        if (q.rxctl[`MACREG_BIT_BCN_ONLY] && rx_ftype_i != MACREG_FT_BEACON) begin
            next_q.frame_accept = 1'b0; // [RL6]
        end
        // polarity: drive the active level on request, idle otherwise
        wake_lvl = q.rxctl[`MACREG_BIT_WAKE_POL] ? wake_req_i : ~wake_req_i; // [RL2]
        next_q.wake_out = wake_lvl;
        next_q.wake_oe_b = ~q.rxctl[`MACREG_BIT_WAKE_EN]; // [RL3]
        next_q.wake_in_s1 = wake_pin_i;
        next_q.wake_in_s2 = q.wake_in_s1;
        next_q.wake_evt = q.rxctl[`MACREG_BIT_WAKE_EN] &
            (q.rxctl[`MACREG_BIT_WAKE_POL] ? q.wake_in_s2 : ~q.wake_in_s2); // [RL2] [RL3]
        next_q.beacon_en = (q.order[7:4] != `MACREG_ORDER_NONE); // [RL8]
        // superframe order ignored when no beacon
        next_q.active_en = next_q.beacon_en && (q.order[3:0] != `MACREG_ORDER_NONE); // [RL9] [RL10]
        next_q.csma_bypass = q.csma[`MACREG_BIT_NO_CS] & ~q.csma[`MACREG_BIT_SLOTTED]
            & q.sw[`MACREG_BIT_SLOT_SWITCH]; // [RL11]
        next_q.ca_en = (q.csma[4:3] != 2'h0); // [RL14]
        bf = q.csma[2:0];
        // undefined codes clamp to the largest defined count
        next_q.bf_valid = (bf <= `MACREG_BF_MAX); // [RL15]
        next_q.max_backoff = next_q.bf_valid ? bf : `MACREG_BF_MAX; // [RL15]
        next_q.pend_bit = q.ack[`MACREG_BIT_PEND_ACK]; // [RL16]
        if (!rst_b_i) begin
            next_q = '0;
            next_q.ext5 = `MACREG_RST_EXT;
            next_q.ext6 = `MACREG_RST_EXT;
            next_q.ext7 = `MACREG_RST_EXT;
            next_q.rxctl = `MACREG_RST_RXCTL;
            next_q.order = `MACREG_RST_ORDER;
            next_q.csma = `MACREG_RST_CSMA; // [RL14] [RL15]
            next_q.ack = `MACREG_RST_ACK; // [RL17]
            next_q.slot = `MACREG_RST_SLOT;
            next_q.sw = `MACREG_RST_SWITCH;
            next_q.frame_accept = 1'b1;
            next_q.wake_out = 1'b1;
            next_q.wake_oe_b = 1'b1;
            next_q.ca_en = 1'b1;
            next_q.max_backoff = 3'h4;
            next_q.bf_valid = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        q <= next_q;
    end

    assign rdata_o = q.rdata;
    assign wake_pin_o = q.wake_out;
    assign wake_pin_oe_b_o = q.wake_oe_b;
    assign wake_evt_o = q.wake_evt;
    assign frame_accept_o = q.frame_accept;
    assign rx_ptr_rst_o = q.ptr_rst;
    assign ext_addr_hi_o = {q.ext7, q.ext6, q.ext5};
    assign beacon_en_o = q.beacon_en;
    assign active_en_o = q.active_en;
    assign beacon_order_o = q.order[7:4];
    assign superframe_order_o = q.order[3:0];
    assign csma_bypass_o = q.csma_bypass;
    assign ble_en_o = q.csma[`MACREG_BIT_BLE];
    assign slotted_o = q.csma[`MACREG_BIT_SLOTTED];
    assign ca_en_o = q.ca_en;
    assign min_be_o = q.csma[4:3];
    assign max_backoff_o = q.max_backoff;
    assign backoff_valid_o = q.bf_valid;
    assign pend_bit_o = q.pend_bit;
    assign ack_wait_o = q.ack[6:0];
    assign first_slot_end_o = q.slot[7:4];
    assign contention_period_end_o = q.slot[3:0];
endmodule

// >>> verification/macreg_host.sv
`timescale 1ns/1ps
module macreg_host (
    input wire logic sys_clk_i, // clock
    input wire logic [7:0] rdata_i, // read data
    output logic [7:0] addr_o = 8'h00, // address
    output logic [7:0] wdata_o = 8'h00, // write data
    output logic wr_o = 1'b0, // write strobe
    output logic rd_o = 1'b0 // read strobe
);
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr_o <= a;
        wdata_o <= (a == 8'h0d) ? (d & 8'h6f) : d;
        wr_o <= 1'b1;
        @(posedge sys_clk_i);
        wr_o <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge sys_clk_i);
        rd_o <= 1'b0;
        #1;
        d = rdata_i;
    endtask
endmodule

// >>> verification/macreg_monitor.sv
`timescale 1ns/1ps
module macreg_monitor (
    input wire logic sys_clk_i, // clock
    input wire logic rst_b_i, // reset
    input wire logic [7:0] addr_i, // address
    input wire logic [7:0] wdata_i, // write data
    input wire logic wr_i, // write
    input wire logic rd_i, // read
    input wire logic [7:0] rdata_o, // read data
    input wire logic rx_ptr_rst_o, // pointer reset
    input wire logic [63:40] ext_addr_hi_o, // address bytes
    input wire logic beacon_en_o, // beacons on
    input wire logic active_en_o, // active part
    input wire logic [3:0] beacon_order_o, // order
    input wire logic [3:0] superframe_order_o, // order
    input wire logic csma_bypass_o, // bypass
    input wire logic slotted_o, // slotted
    input wire logic ca_en_o, // avoidance
    input wire logic [1:0] min_be_o, // exponent
    input wire logic [2:0] max_backoff_o, // backoffs
    input wire logic backoff_valid_o // code defined
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    wire flush_wr = wr_i && addr_i == 8'h0d && wdata_i[0];
    a_rd_idle: assert property (!rd_i |=> rdata_o == 8'h00) else $error("rdata not idle");
    a_rd_unmapped: assert property (rd_i && addr_i == 8'h0e |=> rdata_o == 8'h00) else $error("bad read");
    // a second flush write straight after the first keeps the pulse up one more cycle
    a_flush_pulse: assert property (flush_wr |=> rx_ptr_rst_o ##1
        (rx_ptr_rst_o == $past(flush_wr))) else $error("flush");
    a_flush_cause: assert property (rx_ptr_rst_o |-> $past(flush_wr)) else $error("stray flush");
    a_flush_rd0: assert property (rd_i && addr_i == 8'h0d |=> !rdata_o[0]) else $error("flush bit");
    a_ext_write: assert property (wr_i && addr_i == 8'h0a |=>
        ext_addr_hi_o[47:40] == $past(wdata_i)) else $error("ext byte");
    a_beacon_off: assert property (beacon_en_o == ($past(beacon_order_o) != 4'hf))
        else $error("beacon enable");
    a_active_off: assert property (active_en_o |->
        $past(superframe_order_o) != 4'hf && beacon_en_o) else $error("active enable");
    a_bypass_unslot: assert property (csma_bypass_o |-> !$past(slotted_o)) else $error("bypass");
    a_ca_zero: assert property (ca_en_o == ($past(min_be_o) != 2'h0)) else $error("ca enable");
    a_backoff_clamp: assert property (!backoff_valid_o |-> max_backoff_o == 3'h5) else $error("clamp");
    c_flush: cover property (flush_wr ##1 rx_ptr_rst_o);
    c_bypass: cover property (csma_bypass_o);
    c_invalid: cover property (!backoff_valid_o);
endmodule
bind macreg_top macreg_monitor u_mon (.*);

// >>> verification/macreg_top_tb.sv
`timescale 1ns/1ps
module macreg_top_tb;
    logic sys_clk = 1'b0, rst_b = 1'b0, wreq = 1'b0, ext_lvl = 1'b0;
    logic wr, rd, pin, pin_o, oe_b, evt, acc, prst, ben, aen, byp, ble, slt, caen, bval, pend;
    logic [7:0] addr, wdata, rdata, d;
    logic [2:0] ftype = 3'h0, mbo;
    logic [63:40] ext;
    logic [3:0] bo, so, g1, cap;
    logic [1:0] mbe;
    logic [6:0] aw;
    int n_mismatch = 0, checks_done = 0, cyc = 0;
    always #50 sys_clk = ~sys_clk;
    assign pin = oe_b ? ext_lvl : pin_o;
    macreg_host u_host (.sys_clk_i(sys_clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd));
    macreg_top u_dut (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .rx_ftype_i(ftype), .wake_pin_i(pin),
        .wake_req_i(wreq), .wake_pin_o(pin_o), .wake_pin_oe_b_o(oe_b), .wake_evt_o(evt),
        .frame_accept_o(acc), .rx_ptr_rst_o(prst), .ext_addr_hi_o(ext), .beacon_en_o(ben),
        .active_en_o(aen), .beacon_order_o(bo), .superframe_order_o(so), .csma_bypass_o(byp),
        .ble_en_o(ble), .slotted_o(slt), .ca_en_o(caen), .min_be_o(mbe), .max_backoff_o(mbo),
        .backoff_valid_o(bval), .pend_bit_o(pend), .ack_wait_o(aw), .first_slot_end_o(g1),
        .contention_period_end_o(cap));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic settle();
        repeat (4) @(posedge sys_clk);
        #1;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        u_host.rd_reg(a, d);
        chk("rdata", e, d);
    endtask
    task automatic t_reset();
        logic [7:0] a[9] = '{8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h10, 8'h11, 8'h12, 8'h13, 8'h0e};
        logic [7:0] e[9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h1c, 8'h39, 8'h00, 8'h00};
        foreach (a[i]) rchk(a[i], e[i]);
    endtask
    task automatic t_ext();
        u_host.wr_reg(8'h0a, 8'h5a);
        u_host.wr_reg(8'h0b, 8'hc3);
        u_host.wr_reg(8'h0c, 8'h81);
        rchk(8'h0b, 8'hc3);
        chk("ext", 24'h81c35a, ext);
    endtask
    task automatic t_filter();
        for (int b = 0; b < 4; b++) begin
            u_host.wr_reg(8'h0d, b == 0 ? 8'h00 : 8'h01 << b);
            for (int t = 0; t < 5; t++) begin
                ftype <= 3'(t);
                settle();
                chk("accept", b == 0 || t == (b == 3 ? 3 : b - 1), acc);
            end
        end
        u_host.wr_reg(8'h0d, 8'h01);
        #1 chk("ptr_rst", 1, prst);
        @(posedge sys_clk) #1 chk("ptr_rst", 0, prst);
        rchk(8'h0d, 8'h00);
    endtask
    task automatic t_wake();
        for (int p = 0; p < 2; p++) begin
            u_host.wr_reg(8'h0d, p ? 8'h60 : 8'h20);
            @(posedge sys_clk) wreq <= 1'b0;
            settle();
            chk("idle", {!p[0], 1'b0, 1'b0}, {pin_o, oe_b, evt});
            @(posedge sys_clk) wreq <= 1'b1;
            settle();
            chk("active", {p[0], 1'b1}, {pin_o, evt});
        end
        u_host.wr_reg(8'h0d, 8'h40);
        @(posedge sys_clk) ext_lvl <= 1'b1;
        settle();
        chk("off", 2'b10, {oe_b, evt});
    endtask
    task automatic t_csma();
        u_host.wr_reg(8'h21, 8'h02);
        u_host.wr_reg(8'h11, 8'h80);
        settle();
        chk("bypass", 1, byp);
        u_host.wr_reg(8'h11, 8'ha0);
        settle();
        chk("slotted", 2'b01, {byp, slt});
        u_host.wr_reg(8'h11, 8'h46);
        settle();
        chk("csma", {1'b1, 1'b0, 2'h0, 3'h5, 1'b0}, {ble, caen, mbe, mbo, bval});
        rchk(8'h11, 8'h46);
    endtask
    task automatic t_misc();
        u_host.wr_reg(8'h10, 8'h32);
        u_host.wr_reg(8'h12, 8'h85);
        u_host.wr_reg(8'h13, 8'ha5);
        u_host.wr_reg(8'h0e, 8'h77);
        settle();
        chk("order", 10'h332, {ben, aen, bo, so});
        chk("ack", 8'h85, {pend, aw});
        chk("slot", 8'ha5, {g1, cap});
        rchk(8'h0e, 8'h00);
        u_host.wr_reg(8'h10, 8'h3f);
        settle();
        chk("no active", 2'b10, {ben, aen});
        u_host.wr_reg(8'h10, 8'hf0);
        settle();
        chk("no beacon", 2'b00, {ben, aen});
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_reset();
        t_ext();
        t_filter();
        t_wake();
        t_csma();
        t_misc();
        report_and_stop();
    end
endmodule
